// ===== descriptor_type_checker.sv
/*
 * Descriptor type checker: decodes the kind flag and type field of each
 * descriptor the segmentation pipeline presents, and answers pass or fault
 * one cycle later, per operating mode. Registers on Avalon-MM.
 * Assumes requests and bus come from logic on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module descriptor_type_checker #(
    parameter int CNT_W = 16
) (
    input  wire logic                          clock_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          req_valid_i,
    input  wire type_check_pkg::desc_req_t     req_i,
    input  wire logic [3:0]                    avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [31:0]                   avs_writedata_i,
    input  wire logic [3:0]                    avs_byteenable_i,
    output logic [31:0]                        avs_readdata_o,
    output logic                               avs_waitrequest_o,
    output type_check_pkg::check_result_t      result_o
);

    ////////////////////////////////////////////////////////////////////////
    // State

    type_check_pkg::mode_t     mode;
    type_check_pkg::req_kind_t last_kind;
    logic [CNT_W-1:0]          fault_count;
    logic [CNT_W-1:0]          check_count;
    type_check_pkg::fault_t    next_fault;

    logic is_sys;
    logic is_code;
    logic is_data;
    logic rw_bit;
    logic long_mode;
    logic m64;
    logic is_local;
    logic is_tss_avl;
    logic is_tss;
    logic is_call_gate;
    logic is_intr_gate;
    logic is_task_gate;
    logic long_illegal;
    logic bus_done;
    logic clear_faults;
    logic clear_checks;
    logic fault_event;

    ////////////////////////////////////////////////////////////////////////
    // Descriptor decode

    // The kind flag and type bit 3 name the descriptor class
    assign is_sys    = ~req_i.sys_user;
    assign is_code   = req_i.sys_user & req_i.dtype[type_check_pkg::TYPE_CODE_BIT];
    assign is_data   = req_i.sys_user & ~req_i.dtype[type_check_pkg::TYPE_CODE_BIT];
    assign rw_bit    = req_i.dtype[type_check_pkg::TYPE_RW_BIT];
    assign long_mode = (mode != type_check_pkg::MODE_LEGACY);
    assign m64       = (mode == type_check_pkg::MODE_64);

    // System and gate classes, 16-bit forms included
    assign is_local     = is_sys & (req_i.dtype == type_check_pkg::SYS_LOCAL);
    assign is_tss_avl   = is_sys & ((req_i.dtype == type_check_pkg::SYS_TSS_AVL)
                        | (req_i.dtype == type_check_pkg::SYS_TSS16_AVL));
    assign is_tss       = is_tss_avl | (is_sys & ((req_i.dtype == type_check_pkg::SYS_TSS_BSY)
                        | (req_i.dtype == type_check_pkg::SYS_TSS16_BSY)));
    assign is_call_gate = is_sys & ((req_i.dtype == type_check_pkg::SYS_CALL)
                        | (req_i.dtype == type_check_pkg::SYS_CALL16));
    assign is_intr_gate = is_sys & ((req_i.dtype == type_check_pkg::SYS_INT)
                        | (req_i.dtype == type_check_pkg::SYS_INT16)
                        | (req_i.dtype == type_check_pkg::SYS_TRAP)
                        | (req_i.dtype == type_check_pkg::SYS_TRAP16));
    assign is_task_gate = is_sys & (req_i.dtype == type_check_pkg::SYS_TASK_GATE);

    // Types that exist only outside long mode
    always_comb begin
        long_illegal = 1'b0;
        if (long_mode && is_sys) begin
            case (req_i.dtype)
                type_check_pkg::SYS_TSS16_AVL,
                type_check_pkg::SYS_TSS16_BSY: long_illegal = 1'b1;
                type_check_pkg::SYS_RSVD0:     long_illegal = 1'b1;
                type_check_pkg::SYS_CALL16,
                type_check_pkg::SYS_INT16,
                type_check_pkg::SYS_TRAP16,
                type_check_pkg::SYS_TASK_GATE: long_illegal = 1'b1;
                default:                       long_illegal = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-kind checks; the long-mode type filter takes priority

    always_comb begin
        next_fault = type_check_pkg::F_NONE;
        case (req_i.kind)
            // Same kind whatever the source of the load
            type_check_pkg::K_LOAD_LOCAL: begin
                if (!is_local)
                    next_fault = type_check_pkg::F_LOCAL;
            end
            type_check_pkg::K_LOAD_TASK: begin
                if (!is_tss_avl)
                    next_fault = type_check_pkg::F_TASK;
            end
            type_check_pkg::K_LOAD_CODE: begin
                if (!is_code)
                    next_fault = type_check_pkg::F_CODE_SEL;
            end
            type_check_pkg::K_LOAD_STACK: begin
                if (!(is_data && (rw_bit || m64)))
                    next_fault = type_check_pkg::F_STACK_SEL;
            end
            type_check_pkg::K_LOAD_DATA: begin
                if (!(is_data || (is_code && (rw_bit || m64))))
                    next_fault = type_check_pkg::F_DATA_SEL;
            end
            type_check_pkg::K_FAR_TARGET: begin
                if (!(is_code || is_call_gate
                      || (!long_mode && (is_tss_avl || is_task_gate))))
                    next_fault = type_check_pkg::F_FAR;
            end
            type_check_pkg::K_GATE_TARGET: begin
                if (!is_code)
                    next_fault = type_check_pkg::F_GATE_TGT;
            end
            type_check_pkg::K_TGATE_TARGET: begin
                if (!is_tss)
                    next_fault = type_check_pkg::F_TGATE_TGT;
            end
            type_check_pkg::K_INTERRUPT_RETURN_OP_LINK: begin
                if (!is_tss)
                    next_fault = type_check_pkg::F_LINK;
            end
            type_check_pkg::K_FAR_RETURN: begin
                if (!is_code)
                    next_fault = type_check_pkg::F_RETURN;
            end
            type_check_pkg::K_VECTOR: begin
                if (!(is_intr_gate || is_task_gate))
                    next_fault = type_check_pkg::F_VECTOR;
            end
            type_check_pkg::K_MEM_WRITE: begin
                if (!m64 && is_code)
                    next_fault = type_check_pkg::F_WR_CODE;
                else if (!m64 && is_data && !rw_bit)
                    next_fault = type_check_pkg::F_WR_RO;
            end
            type_check_pkg::K_MEM_READ: begin
                if (!m64 && is_code && !rw_bit)
                    next_fault = type_check_pkg::F_RD_EXEC;
            end
            default: next_fault = type_check_pkg::F_NONE;
        endcase
        // Memory accesses use an already loaded selector, so no system type
        if (long_illegal && req_i.kind != type_check_pkg::K_MEM_WRITE
            && req_i.kind != type_check_pkg::K_MEM_READ)
            next_fault = type_check_pkg::F_LONG_SYS;
    end

    ////////////////////////////////////////////////////////////////////////
    // Result register: one answer per request, the cycle after it

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            result_o  <= '0;
            last_kind <= type_check_pkg::K_LOAD_LOCAL;
        end else begin
            result_o.done  <= req_valid_i;
            result_o.pass  <= req_valid_i && next_fault == type_check_pkg::F_NONE;
            result_o.fault <= req_valid_i && next_fault != type_check_pkg::F_NONE;
            result_o.code  <= req_valid_i ? next_fault : type_check_pkg::F_NONE;
            if (req_valid_i)
                last_kind <= req_i.kind;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: waitrequest drops one cycle after the request

    assign bus_done     = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    assign clear_faults = bus_done && avs_write_i && avs_address_i == type_check_pkg::REG_FAULTS;
    assign clear_checks = bus_done && avs_write_i && avs_address_i == type_check_pkg::REG_CHECKS;
    assign fault_event  = req_valid_i && next_fault != type_check_pkg::F_NONE;

    // Wait state sequencing
    always_ff @(posedge clock_i) begin
        if (!rst_n_i)
            avs_waitrequest_o <= 1'b1;
        else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
            avs_waitrequest_o <= 1'b0;
        else
            avs_waitrequest_o <= 1'b1;
    end

    // Read data captured in the wait cycle, held until the next read
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= type_check_pkg::RDATA_RESET;
        end else if (avs_read_i && avs_waitrequest_o) begin
            case (avs_address_i)
                type_check_pkg::REG_MODE:   avs_readdata_o <= {30'h0, mode};
                type_check_pkg::REG_LAST:   avs_readdata_o <= {20'h0, last_kind,
                                                               result_o.code, 3'h0,
                                                               result_o.pass};
                type_check_pkg::REG_FAULTS: avs_readdata_o <= 32'(fault_count);
                type_check_pkg::REG_CHECKS: avs_readdata_o <= 32'(check_count);
                default:                    avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Mode register; the unused encoding is refused
    always_ff @(posedge clock_i) begin
        if (!rst_n_i)
            mode <= type_check_pkg::MODE_RESET;
        else if (bus_done && avs_write_i && avs_byteenable_i[0]
                 && avs_address_i == type_check_pkg::REG_MODE
                 && avs_writedata_i[1:0] != 2'h2)
            mode <= type_check_pkg::mode_t'(avs_writedata_i[1:0]);
    end

    // Fault counter; a fault in the clearing cycle is kept
    always_ff @(posedge clock_i) begin
        if (!rst_n_i)
            fault_count <= '0;
        else if (fault_event)
            fault_count <= clear_faults ? CNT_W'(1) : fault_count + CNT_W'(1);
        else if (clear_faults)
            fault_count <= '0;
    end

    // Check counter, same clearing rule
    always_ff @(posedge clock_i) begin
        if (!rst_n_i)
            check_count <= '0;
        else if (req_valid_i)
            check_count <= clear_checks ? CNT_W'(1) : check_count + CNT_W'(1);
        else if (clear_checks)
            check_count <= '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_exception;
        req_valid_i |=> result_o.done && (result_o.fault == (result_o.code != 4'h0))
                        && (result_o.pass == !result_o.fault);
    endproperty
    a_exception: assert property (p_exception)
        else $error("fault flag disagrees with cause code");

    property p_task_load;
        req_valid_i && req_i.kind == type_check_pkg::K_LOAD_TASK && req_i.sys_user
        |=> result_o.fault && result_o.code == type_check_pkg::F_TASK;
    endproperty
    a_task_load: assert property (p_task_load)
        else $error("task register took a code or data descriptor");

    property p_stack_legacy;
        req_valid_i && mode == type_check_pkg::MODE_LEGACY
        && req_i.kind == type_check_pkg::K_LOAD_STACK && req_i.sys_user
        && !req_i.dtype[3] && !req_i.dtype[1]
        |=> result_o.code == type_check_pkg::F_STACK_SEL;
    endproperty
    a_stack_legacy: assert property (p_stack_legacy)
        else $error("read-only data accepted into stack selector");

    property p_data_sel;
        req_valid_i && req_i.kind == type_check_pkg::K_LOAD_DATA && req_i.sys_user
        |=> result_o.pass == (($past(req_i.dtype) & 4'hA) != 4'h8
                              || $past(mode) == type_check_pkg::MODE_64);
    endproperty
    a_data_sel: assert property (p_data_sel)
        else $error("data selector verdict wrong");

    property p_far_compat_tss;
        req_valid_i && mode == type_check_pkg::MODE_COMPAT
        && req_i.kind == type_check_pkg::K_FAR_TARGET && !req_i.sys_user
        && req_i.dtype == type_check_pkg::SYS_TSS_AVL
        |=> result_o.fault;
    endproperty
    a_far_compat_tss: assert property (p_far_compat_tss)
        else $error("task state target accepted outside legacy mode");

    property p_vector;
        req_valid_i && req_i.kind == type_check_pkg::K_VECTOR && req_i.sys_user
        |=> result_o.code == type_check_pkg::F_VECTOR;
    endproperty
    a_vector: assert property (p_vector)
        else $error("code or data entry accepted from vector table");

    property p_write_ro;
        req_valid_i && mode != type_check_pkg::MODE_64
        && req_i.kind == type_check_pkg::K_MEM_WRITE && req_i.sys_user
        && !req_i.dtype[3] && !req_i.dtype[1]
        |=> result_o.fault && result_o.code == type_check_pkg::F_WR_RO;
    endproperty
    a_write_ro: assert property (p_write_ro)
        else $error("write into read-only data not blocked");

    property p_read_exec;
        req_valid_i && mode != type_check_pkg::MODE_64
        && req_i.kind == type_check_pkg::K_MEM_READ && req_i.sys_user
        && req_i.dtype[3] && !req_i.dtype[1]
        |=> result_o.code == type_check_pkg::F_RD_EXEC;
    endproperty
    a_read_exec: assert property (p_read_exec)
        else $error("read from execute-only code not blocked");

    property p_long_gate;
        req_valid_i && mode != type_check_pkg::MODE_LEGACY && !req_i.sys_user
        && req_i.kind == type_check_pkg::K_VECTOR
        && req_i.dtype == type_check_pkg::SYS_TASK_GATE
        |=> result_o.code == type_check_pkg::F_LONG_SYS;
    endproperty
    a_long_gate: assert property (p_long_gate)
        else $error("task gate accepted in long mode");

    property p_m64_access;
        req_valid_i && mode == type_check_pkg::MODE_64
        && (req_i.kind == type_check_pkg::K_MEM_WRITE
            || req_i.kind == type_check_pkg::K_MEM_READ)
        |=> result_o.pass;
    endproperty
    a_m64_access: assert property (p_m64_access)
        else $error("memory access blocked in 64-bit mode");

    property p_one_answer;
        !req_valid_i |=> !result_o.done && result_o.code == type_check_pkg::F_NONE;
    endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("answer without a request");

    property p_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait)
        else $error("waitrequest held longer than one cycle");

endmodule // descriptor_type_checker
`default_nettype wire

// ===== pipe_model.sv
/*
 * Model of the segment-load, transfer and memory-access pipeline.
 * Assumes the checker samples its request on the rising core clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
    input  wire logic                 clock_i,
    output logic                      req_valid_o,
    output type_check_pkg::desc_req_t req_o
);
    // Idle at time zero
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // One descriptor for one cycle; idle payload differs from the last one
    task automatic send(input logic [3:0] k, input logic s, input logic [3:0] t);
        @(posedge clock_i);
        req_valid_o <= 1'b1;
        req_o <= {k, s, t};
        @(posedge clock_i);
        req_valid_o <= 1'b0;
        req_o <= {4'hD, ~s, ~t};
    endtask
endmodule // pipe_model
`default_nettype wire

// ===== tb.sv
/*
 * Testbench of the descriptor type checker: vector table per mode, registers.
 * Assumes the package is compiled first and the pipeline model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                          clock = 1'b0;
    logic                          rst_n = 1'b0;
    logic                          rd = 1'b0;
    logic                          wr = 1'b0;
    logic [3:0]                    addr = 4'h0;
    logic [31:0]                   wdata = 32'h0;
    logic [31:0]                   rdata;
    logic                          wait_req;
    logic                          req_valid;
    type_check_pkg::desc_req_t     req;
    type_check_pkg::check_result_t result;
    logic [31:0]                   q;
    logic [3:0]                    mode = 4'h0;
    int                            failures = 0;
    int                            check_count = 0;
    int                            cycles = 0;
    int                            nfault = 0;
    // Entry: mode, kind, code/data flag, type, expected cause
    localparam logic [19:0] VEC [42] = '{
        20'h02023, 20'h02180, 20'h03104, 20'h03120, 20'h04185,
        20'h041A0, 20'h04100, 20'h00020, 20'h00091, 20'h01090,
        20'h01022, 20'h05050, 20'h05090, 20'h05126, 20'h06097,
        20'h06180, 20'h07188, 20'h07090, 20'h08129, 20'h0912A,
        20'h09180, 20'h0A0CB, 20'h0A0E0, 20'h0B10C, 20'h0B18D,
        20'h0A18B, 20'h01182,
        20'h0C18E, 20'h0C1A0, 20'h1101F, 20'h1103F, 20'h1500F,
        20'h1A06F, 20'h1505F, 20'h15096, 20'h12180, 20'h1B18D,
        20'h1A05F,
        20'h3C180, 20'h3B180, 20'h3B100, 20'h33100};

    // 50 ns core clock
    always #25 clock = ~clock;

    pipe_model pipe (.clock_i(clock), .req_valid_o(req_valid), .req_o(req));
    descriptor_type_checker #(.CNT_W(16)) uut (
        .clock_i(clock), .rst_n_i(rst_n), .req_valid_i(req_valid), .req_i(req),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .result_o(result));

    ////////////////////////////////////////////////////////////////////////////
    // Avalon access held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clock);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        while (wait_req !== 1'b0) begin
            @(posedge clock);
        end
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Compare a register word
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
        end
    endtask
    // One request, answer checked in the cycle it stands
    task automatic probe(input logic [19:0] v);
        logic [3:0] e;
        e = v[3:0];
        pipe.send(v[15:12], v[8], v[7:4]);
        #1;
        check_count++;
        if (result.done !== 1'b1 || result.pass !== (e == 4'h0)
            || result.fault !== (e != 4'h0) || result.code !== e) begin
            failures++;
            $display("unexpected at %0t: vector %h gave %b", $time, v, result);
        end
    endtask
    // Verdict
    task automatic wrap_up;
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, type_check_pkg::REG_MODE, 32'h0, q);
        cmp(q, 32'h0);
        bus(1'b1, type_check_pkg::REG_MODE, 32'h2, q);
        bus(1'b0, type_check_pkg::REG_MODE, 32'h0, q);
        cmp(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0, q);
        cmp(q, 32'h0);
        foreach (VEC[i]) begin
            if (VEC[i][19:16] != mode) begin
                mode = VEC[i][19:16];
                bus(1'b1, type_check_pkg::REG_MODE, {28'h0, mode}, q);
            end
            if (VEC[i][3:0] != 4'h0) nfault++;
            probe(VEC[i]);
        end
        bus(1'b0, type_check_pkg::REG_FAULTS, 32'h0, q);
        cmp(q, 32'(nfault));
        bus(1'b0, type_check_pkg::REG_CHECKS, 32'h0, q);
        cmp(q, 32'd42);
        bus(1'b0, type_check_pkg::REG_LAST, 32'h0, q);
        cmp(q, 32'h300);
        bus(1'b1, type_check_pkg::REG_FAULTS, 32'h0, q);
        bus(1'b0, type_check_pkg::REG_FAULTS, 32'h0, q);
        cmp(q, 32'h0);
        wrap_up();
    end
endmodule // tb
`default_nettype wire

// ===== type_check_pkg.sv
/*
 * Shared constants and types of the descriptor type checker:
 * operating modes, request kinds, fault codes, type encodings, register map.
 * Assumes a single core clock; included before every user of these names.
 */
`default_nettype none
package type_check_pkg;

    // Operating modes; the unused encoding 2'h2 is never stored
    typedef enum logic [1:0] {
        MODE_LEGACY = 2'h0,
        MODE_COMPAT = 2'h1,
        MODE_64     = 2'h3
    } mode_t;

    // What the pipeline wants to do with the descriptor
    typedef enum logic [3:0] {
        K_LOAD_LOCAL  = 4'h0,  // Load of local_table_reg
        K_LOAD_TASK   = 4'h1,  // Load of task_reg
        K_LOAD_CODE   = 4'h2,  // Code selector register
        K_LOAD_STACK  = 4'h3,  // Stack selector register
        K_LOAD_DATA   = 4'h4,  // data_sel_0, extra_sel_1..3
        K_FAR_TARGET  = 4'h5,  // Far call or far jump target
        K_GATE_TARGET = 4'h6,  // Selector inside call, interrupt or trap gate
        K_TGATE_TARGET = 4'h7, // Selector inside a task gate
        K_INTERRUPT_RETURN_OP_LINK   = 4'h8,  // Back-link of task_state_block
        K_FAR_RETURN  = 4'h9,  // Far return or interrupt_return_op target
        K_VECTOR      = 4'hA,  // Entry of vector_table
        K_MEM_WRITE   = 4'hB,  // Write through a loaded selector
        K_MEM_READ    = 4'hC   // Read through a loaded selector
    } req_kind_t;

    // Failure cause; zero means passed
    typedef enum logic [3:0] {
        F_NONE      = 4'h0,
        F_LOCAL     = 4'h1,
        F_TASK      = 4'h2,
        F_CODE_SEL  = 4'h3,
        F_STACK_SEL = 4'h4,
        F_DATA_SEL  = 4'h5,
        F_FAR       = 4'h6,
        F_GATE_TGT  = 4'h7,
        F_TGATE_TGT = 4'h8,
        F_LINK      = 4'h9,
        F_RETURN    = 4'hA,
        F_VECTOR    = 4'hB,
        F_WR_RO     = 4'hC,
        F_WR_CODE   = 4'hD,
        F_RD_EXEC   = 4'hE,
        F_LONG_SYS  = 4'hF
    } fault_t;

    // Descriptor under check
    typedef struct packed {
        req_kind_t   kind;
        logic        sys_user;  // 1 = code/data, 0 = system or gate
        logic [3:0]  dtype;
    } desc_req_t;

    // One answer per request
    typedef struct packed {
        logic    done;
        logic    pass;
        logic    fault;
        fault_t  code;
    } check_result_t;

    // System and gate type encodings
    localparam logic [3:0] SYS_RSVD0     = 4'h0;
    localparam logic [3:0] SYS_TSS16_AVL = 4'h1;
    localparam logic [3:0] SYS_LOCAL     = 4'h2;
    localparam logic [3:0] SYS_TSS16_BSY = 4'h3;
    localparam logic [3:0] SYS_CALL16    = 4'h4;
    localparam logic [3:0] SYS_TASK_GATE = 4'h5;
    localparam logic [3:0] SYS_INT16     = 4'h6;
    localparam logic [3:0] SYS_TRAP16    = 4'h7;
    localparam logic [3:0] SYS_TSS_AVL   = 4'h9;
    localparam logic [3:0] SYS_TSS_BSY   = 4'hB;
    localparam logic [3:0] SYS_CALL      = 4'hC;
    localparam logic [3:0] SYS_INT       = 4'hE;
    localparam logic [3:0] SYS_TRAP      = 4'hF;

    // Type field bit positions for code/data descriptors
    localparam int TYPE_CODE_BIT = 3;
    localparam int TYPE_RW_BIT   = 1;

    // Register byte offsets and reset values
    localparam logic [3:0]  REG_MODE    = 4'h0;
    localparam logic [3:0]  REG_LAST    = 4'h4;
    localparam logic [3:0]  REG_FAULTS  = 4'h8;
    localparam logic [3:0]  REG_CHECKS  = 4'hC;
    localparam mode_t       MODE_RESET  = MODE_LEGACY;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage
`default_nettype wire
